// ---- pkg/lap_pkg.sv ----
////////////////////////////////////////////////////////////////////////////////
package lap_pkg;

	// Register addresses on the internal bus
	localparam logic [15:0] LAP_ADDR_PULLUP    = 16'hFFAC;
	localparam logic [15:0] LAP_ADDR_DIRECTION = 16'hFFB0;
	localparam logic [15:0] LAP_ADDR_LATCH     = 16'hFFB2;

	// Operating modes as seen on the mode strap
	localparam logic [1:0]  LAP_MODE_1         = 2'h1;
	localparam logic [1:0]  LAP_MODE_2         = 2'h2;
	localparam logic [1:0]  LAP_MODE_3         = 2'h3;

	// Values after reset, and fixed read values
	localparam logic [7:0]  LAP_DIR_RST_MODE1  = 8'hFF;
	localparam logic [7:0]  LAP_DIR_RST_OTHER  = 8'h00;
	localparam logic [7:0]  LAP_LATCH_RST      = 8'h00;
	localparam logic [7:0]  LAP_PULLUP_RST     = 8'h00;
	localparam logic [7:0]  LAP_DIR_READ       = 8'hFF;
	localparam logic [7:0]  LAP_UNMAPPED_READ  = 8'h00;
	localparam logic [7:0]  LAP_ALL_OFF        = 8'h00;
	localparam logic [7:0]  LAP_ALL_RELEASED   = 8'hFF;

	// Synchroniser depth on pin inputs
	localparam int          LAP_SYNC_STAGES    = 2;

endpackage : lap_pkg

// ---- rtl/lap_port.sv ----
// Functional notes
// - Mode 1: direction bits fixed, read as one
// - Mode 1: pins carry lower address lines
// - Mode 2: direction one gives address/pattern
// - Mode 3: output latch or pattern by enable
// - Modes 2/3: direction write-only, reads ones
// - Modes 2/3: direction clears on reset, hardware standby
// - Port read: latch if output, else pin
// - Output latch read/write, clears, keeps otherwise
// - Pull-up on: control one and direction zero
// - Pull-ups off: mode 1, reset, hardware standby
// - Pull-up control clears, kept in software standby
// - Mode 1 hardware standby: address pins released
// - Mode 2 after reset: all pins input
// - Each pull-up controlled by own bit
// - Direction reset: FF mode 1, else 00
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module lap_port
	import lap_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// Mode strap and standby states
	input  wire logic [1:0]       mode_strap,
	input  wire logic             hw_standby,
	input  wire logic             sw_standby,
	// Register port
	input  wire logic [15:0]      reg_addr,
	input  wire logic [WIDTH-1:0] reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output var  logic [WIDTH-1:0] reg_rdata,
	// Sources sharing the pins
	input  wire logic [WIDTH-1:0] lower_address_lines,
	input  wire logic [WIDTH-1:0] timed_pattern_output,
	input  wire logic [WIDTH-1:0] pattern_output_enable_bits,
	// Pins
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] pin_out,
	output var  logic [WIDTH-1:0] pin_oe_n,
	output var  logic [WIDTH-1:0] pullup_on
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [1:0]       mode;
		logic [WIDTH-1:0] pin_direction_bits;
		logic [WIDTH-1:0] pin_output_latch;
		logic [WIDTH-1:0] pin_pullup_control;
		logic [WIDTH-1:0] rdata;
		logic [WIDTH-1:0] pin_out;
		logic [WIDTH-1:0] pin_oe_n;
		logic [WIDTH-1:0] pullup_on;
	} lap_state_t;

	lap_state_t       st;
	lap_state_t       next_st;
	logic [WIDTH-1:0] pin_sync;

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers

	function automatic logic lap_is_mode1(input logic [1:0] m);
		lap_is_mode1 = (m == LAP_MODE_1);
	endfunction : lap_is_mode1

	// Returns {drive, level} for one pin
	function automatic logic [1:0] lap_pin_drive(
		input logic [1:0] m,
		input logic       dir,
		input logic       pat_en,
		input logic       pat,
		input logic       adr,
		input logic       lat,
		input logic       hws
	);
		logic [1:0] res;
		res = 2'h0;
		if (lap_is_mode1(m)) begin
			// Address bus floats in hardware standby
			res = hws ? 2'h0 : {1'b1, adr};
		end else if (dir) begin
			if (m == LAP_MODE_2) begin
				res = {1'b1, pat_en ? pat : adr};
			end else begin
				res = {1'b1, pat_en ? pat : lat};
			end
		end else begin
			// Direction zero leaves the pin as an input
			res = 2'h0;
		end
		lap_pin_drive = res;
	endfunction : lap_pin_drive

	////////////////////////////////////////////////////////////////////////
	// Pin input synchroniser

	lap_sync #(
		.WIDTH   (WIDTH)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.clk_en  (clk_en),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [1:0] drv;
		logic       wr_ok;
		drv = 2'h0;
		wr_ok = 1'b0;
		next_st = st;
		next_st.rdata = LAP_UNMAPPED_READ;
		if (rst) begin
			// Mode is caught while reset is held
			next_st.mode = mode_strap;
			next_st.pin_direction_bits = lap_is_mode1(mode_strap) ?
				LAP_DIR_RST_MODE1 : LAP_DIR_RST_OTHER;
			next_st.pin_output_latch = LAP_LATCH_RST;
			next_st.pin_pullup_control = LAP_PULLUP_RST;
			next_st.pin_out = LAP_ALL_OFF;
			next_st.pin_oe_n = LAP_ALL_RELEASED;
			next_st.pullup_on = LAP_ALL_OFF;
		end else begin
			// CPU is halted in either standby, so writes are dropped
			wr_ok = reg_wr && !hw_standby && !sw_standby;
			if (wr_ok) begin
				case (reg_addr)
				LAP_ADDR_DIRECTION: begin
					if (!lap_is_mode1(st.mode)) begin
						next_st.pin_direction_bits = reg_wdata;
					end
				end
				LAP_ADDR_LATCH: begin
					next_st.pin_output_latch = reg_wdata;
				end
				LAP_ADDR_PULLUP: begin
					next_st.pin_pullup_control = reg_wdata;
				end
				default: begin
					next_st.pin_output_latch = st.pin_output_latch;
				end
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				LAP_ADDR_DIRECTION: begin
					next_st.rdata = LAP_DIR_READ;
				end
				LAP_ADDR_LATCH: begin
					next_st.rdata = (st.pin_direction_bits &
						st.pin_output_latch) |
						(~st.pin_direction_bits & pin_sync);
				end
				LAP_ADDR_PULLUP: begin
					next_st.rdata = st.pin_pullup_control;
				end
				default: begin
					next_st.rdata = LAP_UNMAPPED_READ;
				end
				endcase
			end
			// Hardware standby reinitialises; software standby keeps all
			if (hw_standby) begin
				next_st.pin_direction_bits = lap_is_mode1(st.mode) ?
					LAP_DIR_RST_MODE1 : LAP_DIR_RST_OTHER;
				next_st.pin_output_latch = LAP_LATCH_RST;
				next_st.pin_pullup_control = LAP_PULLUP_RST;
			end
			// Pins are driven from the next state so a latch write shows
			// on the pins one cycle later, in step with the register
			for (int i = 0; i < WIDTH; i++) begin
				drv = lap_pin_drive(st.mode,
					next_st.pin_direction_bits[i],
					pattern_output_enable_bits[i],
					timed_pattern_output[i],
					lower_address_lines[i],
					next_st.pin_output_latch[i],
					hw_standby);
				next_st.pin_oe_n[i] = ~drv[1];
				next_st.pin_out[i] = drv[1] & drv[0];
			end
			if (lap_is_mode1(st.mode) || hw_standby) begin
				next_st.pullup_on = LAP_ALL_OFF;
			end else begin
				next_st.pullup_on = next_st.pin_pullup_control &
					~next_st.pin_direction_bits;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || clk_en) begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata = st.rdata;
	assign pin_out   = st.pin_out;
	assign pin_oe_n  = st.pin_oe_n;
	assign pullup_on = st.pullup_on;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_sys);
	endclocking

	default disable iff (rst);

	sequence s_dir_read;
		clk_en && reg_rd && (reg_addr == LAP_ADDR_DIRECTION);
	endsequence

	sequence s_port_read;
		clk_en && reg_rd && (reg_addr == LAP_ADDR_LATCH);
	endsequence

	sequence s_latch_write;
		clk_en && reg_wr && (reg_addr == LAP_ADDR_LATCH) &&
			!hw_standby && !sw_standby;
	endsequence

	sequence s_hw_standby;
		clk_en && hw_standby;
	endsequence

	sequence s_mode1_run;
		clk_en && lap_is_mode1(st.mode) && !hw_standby;
	endsequence

	sequence s_mode3_hold;
		clk_en && (st.mode == LAP_MODE_3) && !hw_standby && !reg_wr;
	endsequence

	a_mode1_dir_fixed: assert property (
		lap_is_mode1(st.mode) |-> st.pin_direction_bits == 8'hFF
	) else $error("mode 1 direction not all ones");

	a_mode1_addr_out: assert property (
		s_mode1_run |=> (pin_oe_n == 8'h00) &&
			(pin_out == $past(lower_address_lines))
	) else $error("mode 1 pins do not carry address");

	a_dir_drive_map: assert property (
		!lap_is_mode1(st.mode) |-> pin_oe_n == ~st.pin_direction_bits
	) else $error("pin drive does not match direction");

	a_mode3_out_mux: assert property (
		s_mode3_hold |=> (pin_out & st.pin_direction_bits) ==
			((($past(pattern_output_enable_bits) &
			$past(timed_pattern_output)) |
			(~$past(pattern_output_enable_bits) &
			$past(st.pin_output_latch))) & st.pin_direction_bits)
	) else $error("mode 3 output select wrong");

	a_dir_reads_ones: assert property (
		s_dir_read |=> reg_rdata == 8'hFF
	) else $error("direction read not all ones");

	// Read data stand one enabled cycle only, so a stale value never looks fresh
	a_rdata_idle: assert property (
		clk_en && !reg_rd |=> reg_rdata == 8'h00
	) else $error("read data not cleared after read");

	a_hws_clears: assert property (
		s_hw_standby |=> (st.pin_output_latch == 8'h00) &&
			(st.pin_pullup_control == 8'h00) &&
			(lap_is_mode1(st.mode) || st.pin_direction_bits == 8'h00)
	) else $error("hardware standby did not clear");

	a_port_read_mix: assert property (
		s_port_read |=> reg_rdata ==
			(($past(st.pin_direction_bits) & $past(st.pin_output_latch)) |
			(~$past(st.pin_direction_bits) & $past(pin_sync)))
	) else $error("port read mixes wrong sources");

	a_latch_write: assert property (
		s_latch_write |=> st.pin_output_latch == $past(reg_wdata)
	) else $error("latch write lost");

	a_pullup_gate: assert property (
		(pullup_on & ~(st.pin_pullup_control &
			~st.pin_direction_bits)) == 8'h00
	) else $error("pull-up on without cause");

	a_pullup_off: assert property (
		lap_is_mode1(st.mode) || $past(hw_standby && clk_en) |->
			pullup_on == 8'h00
	) else $error("pull-up on in mode 1 or standby");

	a_swsb_keeps: assert property (
		clk_en && sw_standby && !hw_standby |=>
			$stable(st.pin_pullup_control) &&
			$stable(st.pin_direction_bits)
	) else $error("software standby lost state");

	a_mode1_hws_float: assert property (
		s_hw_standby ##0 lap_is_mode1(st.mode) |=> pin_oe_n == 8'hFF
	) else $error("address pins driven in standby");

	a_reset_dir: assert property (
		$fell(rst) |-> (lap_is_mode1(st.mode) ?
			st.pin_direction_bits == 8'hFF :
			st.pin_direction_bits == 8'h00) && pin_oe_n == 8'hFF
	) else $error("direction wrong after reset");

	a_follow_latch: assert property (
		s_latch_write ##0 (st.mode == LAP_MODE_3) &&
			(st.pin_direction_bits == 8'hFF) &&
			(pattern_output_enable_bits == 8'h00) |=>
			pin_out == $past(reg_wdata)
	) else $error("pin did not follow latch");

endmodule : lap_port
`default_nettype wire

// ---- rtl/lap_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module lap_sync
	import lap_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// Asynchronous pin levels
	input  wire logic [WIDTH-1:0] async_in,
	// Levels in the clk_sys domain
	output var  logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} lap_sync_state_t;

	lap_sync_state_t st;
	lap_sync_state_t next_st;

	// First stage feeds only the second stage
	always_comb begin
		next_st = st;
		if (rst) begin
			next_st = '0;
		end else begin
			next_st.stage1 = async_in;
			next_st.stage2 = st.stage1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst || clk_en) begin
			st <= next_st;
		end
	end

	assign sync_out = st.stage2;

endmodule : lap_sync
`default_nettype wire

// ---- verification/lap_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module lap_pin_model (
	// Clock
	input  wire logic       clk_sys,
	// Design drive
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [7:0] pullup_on,
	// Board drive
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	// Resolved level
	output var  logic [7:0] pin_lvl
);
	// Known start, or a floating pin would stay unknown for ever
	logic [7:0] last = 8'h00;

	always @(posedge clk_sys) begin
		last <= pin_lvl;
	end

	// A floating pin toggles, so a stale level never reads as a match
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i])
				pin_lvl[i] = pin_out[i];
			else if (ext_en[i])
				pin_lvl[i] = ext_val[i];
			else if (pullup_on[i])
				pin_lvl[i] = 1'b1;
			else
				pin_lvl[i] = ~last[i];
		end
	end
endmodule : lap_pin_model
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module testbench;
	import lap_pkg::*;
	typedef struct packed {
		logic [15:0] a;
		logic [7:0]  d;
		logic [7:0]  r;
	} lap_row_t;
	logic        clk_sys = 1'b0, rst = 1'b1, hws = 1'b0, sws = 1'b0;
	logic        wr = 1'b0, rd = 1'b0, en = 1'b1;
	logic [1:0]  strap = 2'h3;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wd = 8'h00, adl = 8'h00, pat = 8'h00, pen = 8'h00;
	logic [7:0]  ext = 8'h5A, ext_en = 8'hFF, rdata, pout, poe, pu, pin;
	logic [7:0]  v;
	int          bad_count = 0, compares = 0, cyc = 0;
	lap_row_t    rows [4] = '{'{16'hFFAC, 8'h3C, 8'h3C},
		'{16'hFFB0, 8'hF0, 8'hFF}, '{16'hFFB2, 8'h99, 8'h9A},
		'{16'hFF00, 8'h12, 8'h00}};

	lap_port i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(en),
		.mode_strap(strap), .hw_standby(hws), .sw_standby(sws),
		.reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .lower_address_lines(adl),
		.timed_pattern_output(pat), .pattern_output_enable_bits(pen),
		.pin_in(pin), .pin_out(pout), .pin_oe_n(poe), .pullup_on(pu));
	lap_pin_model i_pins (.clk_sys(clk_sys), .pin_out(pout),
		.pin_oe_n(poe), .pullup_on(pu), .ext_val(ext), .ext_en(ext_en),
		.pin_lvl(pin));

	always #2 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		// Idle edge, so back-to-back writes never set the strobe twice
		@(posedge clk_sys);
	endtask : wr_reg

	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk_sys);
	endtask : rd_reg

	// Pins are compared once the registered drive has settled
	task automatic chk_pins(input logic [7:0] o, e, p);
		repeat (3) @(posedge clk_sys);
		#1;
		chk(pout, o);
		chk(poe, e);
		chk(pu, p);
		@(posedge clk_sys);
	endtask : chk_pins

	task automatic do_reset(input logic [1:0] m);
		rst <= 1'b1;
		strap <= m;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
	endtask : do_reset

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// Ceiling well above the roughly 120 cycles the tests need
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(LAP_MODE_3);
		chk_pins(8'h00, 8'hFF, 8'h00);
		foreach (rows[k]) begin
			wr_reg(rows[k].a, rows[k].d);
			rd_reg(rows[k].a, v);
			chk(v, rows[k].r);
		end
		chk_pins(8'h90, 8'h0F, 8'h0C);
		$display("test register rows done");
		pat <= 8'h5A;
		pen <= 8'hC0;
		chk_pins(8'h50, 8'h0F, 8'h0C);
		sws <= 1'b1;
		wr_reg(LAP_ADDR_LATCH, 8'h00);
		chk_pins(8'h50, 8'h0F, 8'h0C);
		sws <= 1'b0;
		hws <= 1'b1;
		chk_pins(8'h00, 8'hFF, 8'h00);
		hws <= 1'b0;
		pen <= 8'h00;
		wr_reg(LAP_ADDR_DIRECTION, 8'hFF);
		rd_reg(LAP_ADDR_LATCH, v);
		chk(v, 8'h00);
		rd_reg(LAP_ADDR_PULLUP, v);
		chk(v, 8'h00);
		wr_reg(LAP_ADDR_LATCH, 8'hA5);
		chk_pins(8'hA5, 8'h00, 8'h00);
		$display("test standby done");
		do_reset(LAP_MODE_2);
		chk_pins(8'h00, 8'hFF, 8'h00);
		adl <= 8'h3C;
		pat <= 8'hFF;
		pen <= 8'h01;
		wr_reg(LAP_ADDR_DIRECTION, 8'h0F);
		chk_pins(8'h0D, 8'hF0, 8'h00);
		// Board lets go of the upper pins; only the pull-ups hold them
		ext_en <= 8'h0F;
		wr_reg(LAP_ADDR_PULLUP, 8'hF0);
		chk_pins(8'h0D, 8'hF0, 8'hF0);
		rd_reg(LAP_ADDR_LATCH, v);
		chk(v, 8'hF0);
		$display("test mode 2 done");
		do_reset(LAP_MODE_1);
		chk_pins(8'h3C, 8'h00, 8'h00);
		wr_reg(LAP_ADDR_PULLUP, 8'hFF);
		wr_reg(LAP_ADDR_DIRECTION, 8'h00);
		chk_pins(8'h3C, 8'h00, 8'h00);
		rd_reg(LAP_ADDR_DIRECTION, v);
		chk(v, 8'hFF);
		hws <= 1'b1;
		chk_pins(8'h00, 8'hFF, 8'h00);
		hws <= 1'b0;
		// A frozen block must ignore a write
		en <= 1'b0;
		wr_reg(LAP_ADDR_LATCH, 8'hAA);
		en <= 1'b1;
		rd_reg(LAP_ADDR_LATCH, v);
		chk(v, 8'h00);
		$display("test mode 1 done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
